// ==== logic/srbp_top.v ====
// Back-end packetizer: zero suppression, raw capture, packet builder, packet memory, e-link splitter
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "srbp_defines.vh"
module srbp_top (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // DSP data
  input wire [47:0] corr_samples,
  input wire [191:0] tap_samples,
  input wire [3:0] quiet_count,
  input wire [5:0] cm_mean,
  // Fast commands
  input wire [7:0] fast_cmd,
  // E-link bytes
  output reg [47:0] elink_data,
  output reg [5:0] elink_on
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Header word with even parity over the header
  function [11:0] hdr;
    input [3:0] bx;
    input fl;
    input [5:0] ln;
    hdr = {bx, ^{bx, fl, ln}, fl, ln};
  endfunction

  // Circular memory index
  function [8:0] wrap;
    input [9:0] a;
    if (a >= {1'b0, `SRBP_MEM_WORDS}) begin
      wrap = a[8:0] - `SRBP_MEM_WORDS;
    end else begin
      wrap = a[8:0];
    end
  endfunction

  // ----------------------------------------
  // Reset synchronizer
  // ----------------------------------------
  reg rs1_q;
  reg rst_n;
  // Avoids release races against the clock edge
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // ----------------------------------------
  // Registers and APB slave
  // ----------------------------------------
  reg [19:0] ctrl_q;
  reg [11:0] pat_q;
  reg [11:0] bx_q;
  reg [8:0] cnt_q;
  reg [3:0] supp_cnt_q;
  wire acc = psel & penable;
  wire [8:0] free_w = `SRBP_MEM_WORDS - cnt_q;
  reg [31:0] rd_mux;
  reg map_ok;

  // Read decode
  always @* begin
    map_ok = 1'b1;
    case (paddr)
      `SRBP_A_CTRL: rd_mux = {12'h000, ctrl_q};
      `SRBP_A_PAT: rd_mux = {20'h00000, pat_q};
      `SRBP_A_STAT: rd_mux = {7'h00, free_w, 4'h0, bx_q};
      `SRBP_A_SUPP: rd_mux = {28'h0000000, supp_cnt_q};
      default: begin
        rd_mux = 32'h00000000;
        map_ok = 1'b0;
      end
    endcase
  end

  // One wait state; write commits on the edge that samples pready
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_q <= `SRBP_CTRL_RST;
      pat_q <= `SRBP_PAT_RST;
    end else begin
      pready <= acc & ~pready;
      if (acc & ~pready) begin
        pslverr <= ~map_ok;
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
      if (acc & pready & pwrite) begin
        if (paddr == `SRBP_A_CTRL) begin
          ctrl_q <= pwdata[19:0];
        end
        if (paddr == `SRBP_A_PAT) begin
          pat_q <= pwdata[11:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Zero suppressor
  // ----------------------------------------
  reg [47:0] s1_q;
  reg [7:0] act_q;
  reg [95:0] sparse_vec_q;
  reg [3:0] q1_q, q2_q;
  reg [5:0] m1_q, m2_q;
  reg [7:0] c1_q, c2_q;
  reg [95:0] vec_d;
  reg [3:0] n_d;
  wire [5:0] th = ctrl_q[`SRBP_F_TH];
  integer i;
  integer m;

  // Compact active channels, highest channel first
  always @* begin
    vec_d = 96'h0;
    n_d = 4'h0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (act_q[i]) begin
        vec_d[95 - 12 * n_d -: 12] = {4'h0, i[2:0], s1_q[6 * i +: 5]};
        n_d = n_d + 4'h1;
      end
    end
  end

  // Two stages; commands and DSP monitors follow the same depth
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 48'h0;
      act_q <= 8'h00;
      sparse_vec_q <= 96'h0;
      supp_cnt_q <= 4'h0;
      q1_q <= 4'h0;
      q2_q <= 4'h0;
      m1_q <= 6'h00;
      m2_q <= 6'h00;
      c1_q <= 8'h00;
      c2_q <= 8'h00;
    end else begin
      s1_q <= corr_samples;
      for (m = 0; m < 8; m = m + 1) begin
        // Zero threshold must pass negative samples too
        act_q[m] <= (th == 6'h00) | ($signed(corr_samples[6 * m +: 6]) >= $signed(th));
      end
      sparse_vec_q <= vec_d;
      supp_cnt_q <= n_d;
      q1_q <= quiet_count;
      q2_q <= q1_q;
      m1_q <= cm_mean;
      m2_q <= m1_q;
      c1_q <= fast_cmd;
      c2_q <= c1_q;
    end
  end

  // ----------------------------------------
  // Raw capture and crossing counter
  // ----------------------------------------
  reg [47:0] raw_q;
  // Single register: a second raw command inside the pipeline depth overwrites it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_q <= 48'h0;
      bx_q <= 12'h000;
    end else begin
      if (fast_cmd[`SRBP_C_RAW]) begin
        raw_q <= tap_samples[48 * ctrl_q[`SRBP_F_TAP] +: 48];
      end
      bx_q <= c2_q[`SRBP_C_CNTCLR] ? 12'h000 : bx_q + 12'h001;
    end
  end

  // ----------------------------------------
  // Packet builder
  // ----------------------------------------
  reg [107:0] pk;
  reg [3:0] plen;
  wire [3:0] bx = bx_q[3:0];
  wire [11:0] mon = {q2_q, m2_q, 1'b0, ^{q2_q, m2_q}};

  // Packet type by priority; calibrate and snapshot carry no packet effect here
  always @* begin
    pk = 108'h0;
    plen = 4'h1;
    if (c2_q[`SRBP_C_SYNC]) begin
      pk[107:84] = {bx_q, pat_q};
      plen = 4'h2;
    end else if (c2_q[`SRBP_C_HDR]) begin
      pk[107:96] = hdr(bx, 1'b1, `SRBP_LEN_HDR);
    end else if (c2_q[`SRBP_C_VETO]) begin
      pk[107:96] = hdr(bx, 1'b1, `SRBP_LEN_VETO);
    end else if (c2_q[`SRBP_C_RAW]) begin
      if (free_w < `SRBP_RAW_MIN) begin
        pk[107:96] = hdr(bx, 1'b1, `SRBP_LEN_RFULL);
      end else begin
        pk[107:36] = {hdr(bx, 1'b1, `SRBP_LEN_RAW), mon, raw_q};
        plen = 4'h6;
      end
    end else if (({2'b00, supp_cnt_q} > `SRBP_HIT_MAX) || ({2'b00, supp_cnt_q} >= ctrl_q[`SRBP_F_LIM])) begin
      pk[107:96] = hdr(bx, 1'b1, `SRBP_LEN_BUSY);
    end else if (free_w < {5'h00, supp_cnt_q}) begin
      pk[107:96] = hdr(bx, 1'b1, `SRBP_LEN_FULL);
    end else begin
      pk = {hdr(bx, 1'b0, {2'b00, supp_cnt_q}), sparse_vec_q};
      plen = 4'h1 + supp_cnt_q;
    end
  end

  // ----------------------------------------
  // Packet memory
  // ----------------------------------------
  reg [11:0] mem [0:431];
  reg [8:0] wp_q, rp_q;
  reg [2:0] rd_n;
  wire fe_clr = c2_q[`SRBP_C_FECLR];
  // A packet that does not fit whole is dropped rather than split
  wire [3:0] wr_n = (({5'h00, plen} <= free_w) && !fe_clr) ? plen : 4'h0;
  integer j;

  // Multi-word write port and occupancy
  always @(posedge clk) begin
    for (j = 0; j < 9; j = j + 1) begin
      if (j < wr_n) begin
        mem[wrap({1'b0, wp_q} + j[9:0])] <= pk[107 - 12 * j -: 12];
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= 9'h000;
      rp_q <= 9'h000;
      cnt_q <= 9'h000;
    end else if (fe_clr) begin
      wp_q <= 9'h000;
      rp_q <= 9'h000;
      cnt_q <= 9'h000;
    end else begin
      wp_q <= wrap({1'b0, wp_q} + {6'h00, wr_n});
      rp_q <= wrap({1'b0, rp_q} + {7'h00, rd_n});
      cnt_q <= cnt_q + {5'h00, wr_n} - {6'h00, rd_n};
    end
  end

  // ----------------------------------------
  // Idle inserter and e-link splitter
  // ----------------------------------------
  reg [95:0] buf_q, sh;
  reg [6:0] fill_q, f1;
  reg [3:0] grp_q, g;
  reg [11:0] w;
  reg ok, send;
  reg [2:0] act;
  reg [5:0] need;
  reg [47:0] el;
  reg [5:0] on;
  integer k;
  wire [3:0] grp_set = (ctrl_q[`SRBP_F_IDLE] == 4'h0) ? 4'h1 : ctrl_q[`SRBP_F_IDLE];

  // Drain bytes from the top, then refill with up to four words
  always @* begin
    act = {1'b0, ctrl_q[`SRBP_F_XL]} + 3'd3;
    need = {act, 3'b000};
    send = (fill_q >= {1'b0, need});
    sh = buf_q;
    f1 = fill_q;
    g = grp_q;
    rd_n = 3'h0;
    w = 12'h000;
    ok = 1'b0;
    el = 48'h0;
    on = 6'h00;
    for (k = 0; k < 6; k = k + 1) begin
      if (k < act) begin
        on[5 - k] = 1'b1;
        if (send) begin
          el[8 * (5 - k) +: 8] = buf_q[95 - 8 * k -: 8];
        end
      end
    end
    if (send) begin
      sh = buf_q << need;
      f1 = fill_q - {1'b0, need};
    end
    for (k = 0; k < 4; k = k + 1) begin
      ok = 1'b0;
      if (f1 <= 7'd84) begin
        // A started idle group finishes before stored data resumes
        if (g != 4'h0) begin
          w = `SRBP_IDLE_WORD;
          g = g - 4'h1;
          ok = 1'b1;
        end else if ({6'h00, rd_n} < cnt_q) begin
          w = mem[wrap({1'b0, rp_q} + {7'h00, rd_n})];
          rd_n = rd_n + 3'h1;
          ok = 1'b1;
        end else if ({6'h00, rd_n} == cnt_q) begin
          // Every stored word is taken: idles fill the rest, or a one-word backlog would starve the links
          w = `SRBP_IDLE_WORD;
          g = grp_set - 4'h1;
          ok = 1'b1;
        end
      end
      if (ok) begin
        sh = sh | ({w, 84'h0} >> f1);
        f1 = f1 + 7'd12;
      end
    end
  end

  // Stream state and registered link outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_q <= 96'h0;
      fill_q <= 7'h00;
      grp_q <= 4'h0;
      elink_data <= 48'h0;
      elink_on <= 6'h00;
    end else begin
      buf_q <= sh;
      fill_q <= f1;
      grp_q <= g;
      elink_data <= el;
      elink_on <= on;
    end
  end

endmodule // srbp_top

// ==== logic/srbp_defines.vh ====
// Constants for the strip readout back-end packetizer
`ifndef SRBP_DEFINES_VH
`define SRBP_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SRBP_A_CTRL 12'h000
`define SRBP_A_PAT 12'h004
`define SRBP_A_STAT 12'h008
`define SRBP_A_SUPP 12'h00C
// ----------------------------------------
// Control register fields and reset values
// ----------------------------------------
`define SRBP_F_TH 5:0
`define SRBP_F_TAP 7:6
`define SRBP_F_XL 9:8
`define SRBP_F_IDLE 13:10
`define SRBP_F_LIM 19:14
`define SRBP_CTRL_RST 20'hFCC00
`define SRBP_PAT_RST 12'hA5C
// ----------------------------------------
// Fast command bit positions
// ----------------------------------------
`define SRBP_C_CAL 0
`define SRBP_C_SYNC 1
`define SRBP_C_SNAP 2
`define SRBP_C_VETO 3
`define SRBP_C_RAW 4
`define SRBP_C_HDR 5
`define SRBP_C_FECLR 6
`define SRBP_C_CNTCLR 7
// ----------------------------------------
// Packet type codes and sizes
// ----------------------------------------
`define SRBP_LEN_IDLE 6'h30
`define SRBP_LEN_VETO 6'h11
`define SRBP_LEN_HDR 6'h12
`define SRBP_LEN_BUSY 6'h13
`define SRBP_LEN_FULL 6'h14
`define SRBP_LEN_RFULL 6'h15
`define SRBP_LEN_RAW 6'h06
`define SRBP_IDLE_WORD 12'h0F0
`define SRBP_MEM_WORDS 9'd432
`define SRBP_RAW_MIN 9'd67
`define SRBP_HIT_MAX 6'd63
`endif

// ==== tb/srbp_props.sv ====
// Port checker for the packetizer, with its bind
`timescale 1ns/1ps
// ----------------------------------------
// Bus answer and link checks
// ----------------------------------------
module srbp_props (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Links
  input wire [47:0] elink_data,
  input wire [5:0] elink_on
);
  // Cycles since reset left; the link register needs a few to load
  logic [3:0] up_q;
  wire mapped_w = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
  wire [47:0] on_w = {{8{elink_on[5]}}, {8{elink_on[4]}}, {8{elink_on[3]}},
    {8{elink_on[2]}}, {8{elink_on[1]}}, {8{elink_on[0]}}};
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q <= 4'h0;
    end else if (up_q != 4'h8) begin
      up_q <= up_q + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Access phase waiting, then a one-cycle answer
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  AST_ONE_WAIT: assert property (s_wait |=> s_answer)
    else $error("answer not one cycle after access");
  AST_ANSWER_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("answer outside access phase");
  AST_UNMAPPED_ERR: assert property (pready && !mapped_w |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (pready && mapped_w |-> !pslverr)
    else $error("mapped access refused");
  AST_WRITE_ZERO: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write answer carries data");
  AST_ANSWER_HOLDS: assert property (!pready |-> $stable(pslverr) && $stable(prdata))
    else $error("answer changed between transfers");
  AST_BASE_LINKS: assert property (up_q == 4'h8 |-> elink_on[5:3] == 3'h7)
    else $error("base links not on");
  AST_LINK_SET: assert property (up_q == 4'h8 |-> elink_on inside {6'h38, 6'h3C, 6'h3E, 6'h3F})
    else $error("link set not contiguous");
  AST_OFF_QUIET: assert property ((elink_data & ~on_w) == 48'h0)
    else $error("inactive link carries data");
endmodule // srbp_props
bind srbp_top srbp_props u_props (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .elink_data, .elink_on);

// ==== tb/srbp_daq_rx.sv ====
// Receiver model: rebuilds 12-bit words from the e-link bytes
`timescale 1ns/1ps
// ----------------------------------------
// Word rebuild and counting
// ----------------------------------------
module srbp_daq_rx (
  // Clock and links
  input wire clk,
  input wire reset_n,
  input wire [47:0] elink_data,
  input wire [5:0] elink_on,
  // Findings
  input wire [11:0] pattern,
  output logic [15:0] idle_cnt,
  output logic [7:0] raw_cnt,
  output logic [7:0] par_bad,
  output logic pat_seen
);
  logic [11:0] acc;
  int nb;
  logic run;
  // Zero cycles before the first byte are fill, so alignment starts there
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {acc, run, idle_cnt, raw_cnt, par_bad, pat_seen} = '0;
      nb = 0;
    end else if (run || elink_data != 48'h0) begin
      run = 1'h1;
      for (int l = 5; l >= 0; l--) begin
        for (int b = 7; b >= 0 && elink_on[l]; b--) begin
          acc = {acc[10:0], elink_data[8 * l + b]};
          nb++;
          if (nb == 12) begin
            nb = 0;
            if (acc == 12'h0F0) idle_cnt++;
            if (acc[6:0] == 7'h46) begin
              raw_cnt++;
              par_bad += {7'h0, ^acc};
            end
            if (acc == pattern) pat_seen = 1'h1;
          end
        end
      end
    end
  end
endmodule // srbp_daq_rx

// ==== tb/testbench.sv ====
// Self-checking bench for the packetizer
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // Signals, rows and models
  // ----------------------------------------
  typedef struct packed {
    logic [5:0] th;
    logic [47:0] s;
    logic [1:0] xl;
    logic [3:0] n;
  } srbp_row_t;
  localparam logic [47:0] MIX = {6'h07, 6'h00, 6'h05, 6'h20, 6'h1F, 6'h06, 6'h04, 6'h05};
  // Threshold, samples, extra links, expected active channel count
  srbp_row_t rows [5] = '{'{6'h00, 48'hFFFFFFFFFFFF, 2'h0, 4'h8}, '{6'h05, MIX, 2'h1, 4'h5},
    '{6'h1F, MIX, 2'h2, 4'h1}, '{6'h20, MIX, 2'h3, 4'h8}, '{6'h3F, 48'hFBEFBEFBEFBE, 2'h0, 4'h0}};
  logic clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [47:0] corr_samples = 48'h0;
  logic [191:0] tap_samples = 192'h0;
  logic [3:0] quiet_count = 4'h0;
  logic [5:0] cm_mean = 6'h00;
  logic [7:0] fast_cmd = 8'h00;
  wire [31:0] prdata;
  wire pready, pslverr, pat_seen;
  wire [47:0] elink_data;
  wire [5:0] elink_on;
  wire [15:0] idle_cnt;
  wire [7:0] raw_cnt, par_bad;
  int error_cnt = 0, samples_checked = 0;
  srbp_top u_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .corr_samples, .tap_samples, .quiet_count, .cm_mean, .fast_cmd, .elink_data, .elink_on);
  srbp_daq_rx u_rx (.clk, .reset_n, .elink_data, .elink_on, .pattern(12'h123), .idle_cnt, .raw_cnt,
    .par_bad, .pat_seen);
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A used-up wait is a mismatch and ends the run
  task automatic limit(input int n);
    if (n >= 1000) begin
      error_cnt++;
      end_sim;
    end
  endtask
  // One bus transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 1000);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    limit(n);
    @(posedge clk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    int i0;
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      corr_samples <= rows[i].s;
      apb(1'h1, 12'h000, 32'hFCC00 | {22'h0, rows[i].xl, 2'h0, rows[i].th});
      repeat (2) @(posedge clk);
      apb(1'h0, 12'h00C, 32'h0);
      check("hit count", rd, {28'h0, rows[i].n});
      check("links", {26'h0, elink_on}, {26'h0, 6'h38 | (6'h38 >> rows[i].xl)});
    end
    // Reset mid-run, then reset values, a read-only write and an unmapped address
    reset_n <= 1'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge clk);
    apb(1'h0, 12'h000, 32'h0);
    check("ctrl reset", rd, 32'hFCC00);
    apb(1'h0, 12'h004, 32'h0);
    check("pat reset", rd, 32'hA5C);
    apb(1'h1, 12'h00C, 32'hF);
    apb(1'h0, 12'h00C, 32'h0);
    check("count read only", rd, 32'h8);
    apb(1'h0, 12'h010, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    // Empty crossings on six links let the memory drain to idles
    apb(1'h1, 12'h004, 32'h123);
    corr_samples <= 48'h0;
    apb(1'h1, 12'h000, 32'hFCF1F);
    i0 = idle_cnt;
    for (n = 0; n < 1000 && idle_cnt == i0; n++) @(posedge clk);
    limit(n);
    fast_cmd <= 8'h10;
    @(posedge clk);
    fast_cmd <= 8'h00;
    for (n = 0; n < 1000 && raw_cnt == 8'h00; n++) @(posedge clk);
    limit(n);
    check("raw packets", {24'h0, raw_cnt}, 32'h1);
    check("raw parity", {24'h0, par_bad}, 32'h0);
    fast_cmd <= 8'h02;
    @(posedge clk);
    fast_cmd <= 8'h00;
    for (n = 0; n < 1000 && pat_seen !== 1'h1; n++) @(posedge clk);
    limit(n);
    check("sync pattern", {31'h0, pat_seen}, 32'h1);
    // Count clear acts two cycles late; the read latches the count one setup cycle after it
    fast_cmd <= 8'h80;
    @(posedge clk);
    fast_cmd <= 8'h00;
    repeat (2) @(posedge clk);
    apb(1'h0, 12'h008, 32'h0);
    check("crossing count", {20'h0, rd[11:0]}, 32'h1);
    end_sim;
  end
endmodule // testbench
